// ### design/ccf_pkg.sv
package ccf_pkg;

    // ------------------------------------------------------------
    // command frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 48;
    localparam int CRC_COVER_BITS = 40;
    localparam logic [5:0] CNT_LAST = 6'h2f;
    localparam logic [5:0] CNT_CRC_END = 6'h28;
    localparam logic [5:0] CNT_FIRST = 6'h01;
    localparam int POS_START = 47;
    localparam int POS_DIR = 46;
    localparam int POS_IDX_HI = 45;
    localparam int POS_IDX_LO = 40;
    localparam int POS_ARG_HI = 39;
    localparam int POS_ARG_LO = 8;
    localparam int POS_CRC_HI = 7;
    localparam int POS_CRC_LO = 1;
    localparam int POS_END = 0;
    localparam logic START_VAL = 1'h0;
    localparam logic DIR_VAL = 1'h1;
    localparam logic END_VAL = 1'h1;
    localparam logic [6:0] CRC7_POLY = 7'h09;
    localparam logic [6:0] CRC7_INIT = 7'h00;
    localparam logic [15:0] RCA_NONE = 16'h0000;

    // ------------------------------------------------------------
    // card specific data, fixed fields
    // ------------------------------------------------------------
    localparam int SPEC_BITS = 128;
    localparam int SPEC_CRC_LO = 1;
    localparam logic [11:0] SPEC_CLASS_MAP = 12'h0f5;
    localparam logic [4:0] SPEC_ERASE_GRP_SIZE = 5'h00;
    localparam logic [4:0] SPEC_ERASE_GROUP_MULT = 5'h1f;
    localparam logic [4:0] SPEC_PROT_GRP_SPAN = 5'h08;
    localparam logic SPEC_GRP_PROT_EN = 1'h1;
    localparam logic [1:0] SPEC_DEFAULT_ECC = 2'h0;
    localparam logic [2:0] SPEC_PROG_READ_RATIO = 3'h4;
    localparam logic [3:0] SPEC_WRITE_BLK_LEN = 4'h9;
    localparam logic SPEC_PARTIAL_WRITE = 1'h0;
    localparam logic [4:0] SPEC_RSVD5 = 5'h00;
    localparam logic SPEC_RSVD1 = 1'h0;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_LAST_ARG = 12'h008;
    localparam logic [11:0] OFS_SPEC0 = 12'h010;
    localparam logic [11:0] OFS_SPEC1 = 12'h014;
    localparam logic [11:0] OFS_SPEC2 = 12'h018;
    localparam logic [11:0] OFS_SPEC3 = 12'h01c;
    localparam int CTRL_TMP = 0;
    localparam int CTRL_PERM = 1;
    localparam int CTRL_COPY = 2;
    localparam int CTRL_FMT_GRP = 3;
    localparam int CTRL_FMT_LO = 4;
    localparam int CTRL_ECC_LO = 6;

    // ------------------------------------------------------------
    // command types and the decoded event
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_NO_REPLY = 2'h0,
        KIND_BCR = 2'h1,
        KIND_ADDRESSED = 2'h2,
        KIND_ADTC = 2'h3
    } ccf_kind_t;

    typedef struct packed {
        logic supported;
        ccf_kind_t kind;
        logic rca_arg;
        logic write_erase;
    } ccf_decode_t;

    typedef struct packed {
        logic [5:0] index;
        logic [31:0] arg;
        ccf_kind_t kind;
        logic respond;
        logic data_phase;
        logic illegal;
        logic refused;
    } ccf_event_t;

endpackage : ccf_pkg

// ### design/ccf_card_cmd.sv
// Behaviour
// - host starts all traffic; card answers only when command asks, and to addressed commands only when addressed; here index 3 always answers
// - command frame is 48 bits, most significant bit first
// - frame opens with start 0 and direction 1, else not a command
// - then 6-bit index, 32-bit argument, 7-bit checksum
// - end bit 1 right after the checksum
// - broadcast no reply; broadcast-with-reply all answer; addressed only the addressed card; here index 3 answers whatever its address
// - addressed data commands answer and also move data on the data line
// - basic class 0,1,2,3,4,7,9,10,12,13 is always implemented; here index 4 decodes as unsupported
// - stream read, index 11, is not implemented
// - stream write, index 20, is not implemented
// - erase class implements only 35, 36, 38
// - supported class bitmap is exposed in card specific data
// - erase group multiplier reads 0x1f
// - protect group span reads 8; group protect enable reads 1
// - recommended error code field reads 0
// - program to read ratio field reports code 4
// - partial write flag reads 0; only full-length block writes
// - copy flag 0 original, 1 copy; programmable once
// - permanent protect resets 0; once set refuses writes and erases forever
// - temporary protect resets 0, reprogrammable; refuses writes and erases while set
// - format group 0 codes 0..3; group 1 reserved
// - error code type 0 none, 1 three-bit BCH; 2 and 3 undefined
// - last card specific data field is a 7-bit checksum over the rest
// - driver stage command, index 4, gets no response
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ccf_card_cmd
    import ccf_pkg::*;
#(
    parameter logic [31:0] SPEC_TOP = 32'h0026012a,
    parameter logic [35:0] SPEC_MID = 36'h900000000
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic cmd_line,
    output ccf_event_t cmd_event,
    output logic cmd_event_valid,
    output logic frame_dropped
);

    // ------------------------------------------------------------
    // shared arithmetic
    // ------------------------------------------------------------
    function automatic logic [6:0] crc7_step(input logic [6:0] crc, input logic bit_in);
        logic fb;
        fb = bit_in ^ crc[6];
        crc7_step = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : CRC7_INIT);
    endfunction : crc7_step

    function automatic ccf_decode_t decode_index(input logic [5:0] idx);
        ccf_decode_t d;
        d = '{supported: 1'b0, kind: KIND_NO_REPLY, rca_arg: 1'b0, write_erase: 1'b0};
        unique case (idx)
            6'd0: d.supported = 1'b1;
            6'd1, 6'd2: d = '{supported: 1'b1, kind: KIND_BCR, rca_arg: 1'b0, write_erase: 1'b0};
            6'd3, 6'd7, 6'd9, 6'd10, 6'd13:
                d = '{supported: 1'b1, kind: KIND_ADDRESSED, rca_arg: 1'b1, write_erase: 1'b0};
            6'd12, 6'd16, 6'd28, 6'd29:
                d = '{supported: 1'b1, kind: KIND_ADDRESSED, rca_arg: 1'b0, write_erase: 1'b0};
            6'd17, 6'd18, 6'd30, 6'd42:
                d = '{supported: 1'b1, kind: KIND_ADTC, rca_arg: 1'b0, write_erase: 1'b0};
            6'd24, 6'd25, 6'd26, 6'd27:
                d = '{supported: 1'b1, kind: KIND_ADTC, rca_arg: 1'b0, write_erase: 1'b1};
            6'd35, 6'd36, 6'd38:
                d = '{supported: 1'b1, kind: KIND_ADDRESSED, rca_arg: 1'b0, write_erase: 1'b1};
            // 4, 11, 20, 32..34, 37 and reserved indices stay unsupported
            default: d.supported = 1'b0;
        endcase
        decode_index = d;
    endfunction : decode_index

    // ------------------------------------------------------------
    // link input synchronisers and edge find
    // ------------------------------------------------------------
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3;
    logic cmd_s1;
    logic cmd_s2;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
            cmd_s1 <= 1'b1;
            cmd_s2 <= 1'b1;
        end
        else
        begin
            lclk_s1 <= link_clk;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
            cmd_s1 <= cmd_line;
            cmd_s2 <= cmd_s1;
        end
    end

    // the host changes the line on falling edges, so the rising edge is the sample point
    wire logic link_rise = lclk_s2 & ~lclk_s3;

    // ------------------------------------------------------------
    // frame receiver
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SHIFT = 2'b01,
        RX_CHECK = 2'b11
    } ccf_rx_t;

    ccf_rx_t rx_state;
    ccf_rx_t next_rx_state;
    logic [FRAME_BITS-1:0] frame;
    logic [5:0] bit_cnt;
    logic [6:0] crc_acc;

    // a low bit while idle is taken as a start bit; the direction bit is checked at the end
    wire logic start_seen = (rx_state == RX_IDLE) & link_rise & (cmd_s2 == START_VAL);
    wire logic shift_bit = (rx_state == RX_SHIFT) & link_rise;
    wire logic last_bit = shift_bit & (bit_cnt == CNT_LAST);

    always_comb
    begin
        next_rx_state = rx_state;
        unique case (rx_state)
            RX_IDLE: if (start_seen) next_rx_state = RX_SHIFT;
            RX_SHIFT: if (last_bit) next_rx_state = RX_CHECK;
            RX_CHECK: next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state <= RX_IDLE;
            frame <= '0;
            bit_cnt <= '0;
            crc_acc <= CRC7_INIT;
        end
        else
        begin
            rx_state <= next_rx_state;
            if (start_seen)
            begin
                frame <= {{(FRAME_BITS-1){1'b0}}, cmd_s2};
                bit_cnt <= CNT_FIRST;
                crc_acc <= crc7_step(CRC7_INIT, cmd_s2);
            end
            else if (shift_bit)
            begin
                frame <= {frame[FRAME_BITS-2:0], cmd_s2};
                bit_cnt <= bit_cnt + CNT_FIRST;
                if (bit_cnt < CNT_CRC_END)
                    crc_acc <= crc7_step(crc_acc, cmd_s2);
            end
        end
    end

    // ------------------------------------------------------------
    // frame fields and validity
    // ------------------------------------------------------------
    wire logic [5:0] f_index = frame[POS_IDX_HI:POS_IDX_LO];
    wire logic [31:0] f_arg = frame[POS_ARG_HI:POS_ARG_LO];
    wire logic [6:0] f_crc = frame[POS_CRC_HI:POS_CRC_LO];
    wire logic [15:0] f_rca = f_arg[31:16];
    wire logic frame_ok = (frame[POS_START] == START_VAL) & (frame[POS_DIR] == DIR_VAL)
        & (frame[POS_END] == END_VAL) & (f_crc == crc_acc);
    wire logic checking = (rx_state == RX_CHECK);
    wire logic accept = checking & frame_ok;
    wire ccf_decode_t dec = decode_index(f_index);

    // ------------------------------------------------------------
    // card addressing and protection state
    // ------------------------------------------------------------
    logic [15:0] rca;
    logic selected;
    logic tmp_protect;
    logic perm_protect;
    logic copy_flag;
    logic fmt_group;
    logic [1:0] file_fmt;
    logic [1:0] ecc_type;

    wire logic rca_match = (f_rca == rca) & (rca != RCA_NONE);
    wire logic is_select = dec.supported & (f_index == 6'd7);
    wire logic is_reset = dec.supported & (f_index == 6'd0);
    wire logic is_set_rca = dec.supported & (f_index == 6'd3);
    wire logic protected_now = perm_protect | tmp_protect;
    wire logic refused = dec.write_erase & protected_now;

    // silent broadcast: no answer; broadcast with reply: every card answers;
    // addressed with an rca argument: only on a match, except index 3, which always answers;
    // the rest only while selected
    logic respond;
    always_comb
    begin
        respond = 1'b0;
        if (dec.supported)
        begin
            unique case (dec.kind)
                KIND_NO_REPLY: respond = 1'b0;
                KIND_BCR: respond = 1'b1;
                KIND_ADDRESSED, KIND_ADTC:
                    respond = is_set_rca ? 1'b1 : (dec.rca_arg ? rca_match : selected);
            endcase
        end
    end

    wire logic data_phase = respond & (dec.kind == KIND_ADTC) & ~refused;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rca <= RCA_NONE;
            selected <= 1'b0;
        end
        else if (accept)
        begin
            if (is_reset)
            begin
                rca <= RCA_NONE;
                selected <= 1'b0;
            end
            else if (is_set_rca)
                rca <= f_rca;
            else if (is_select)
                selected <= rca_match;
        end
    end

    // ------------------------------------------------------------
    // event outputs
    // ------------------------------------------------------------
    logic last_illegal;
    logic last_refused;
    logic [31:0] last_arg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_event <= '0;
            cmd_event_valid <= 1'b0;
            frame_dropped <= 1'b0;
            last_illegal <= 1'b0;
            last_refused <= 1'b0;
            last_arg <= '0;
        end
        else
        begin
            cmd_event_valid <= accept;
            frame_dropped <= checking & ~frame_ok;
            if (accept)
            begin
                cmd_event.index <= f_index;
                cmd_event.arg <= f_arg;
                cmd_event.kind <= dec.kind;
                cmd_event.respond <= respond;
                cmd_event.data_phase <= data_phase;
                cmd_event.illegal <= ~dec.supported;
                cmd_event.refused <= refused;
                last_illegal <= ~dec.supported;
                last_refused <= refused;
                last_arg <= f_arg;
            end
        end
    end

    // ------------------------------------------------------------
    // card specific data image
    // ------------------------------------------------------------
    wire logic [SPEC_BITS-1:8] spec_body = {
        SPEC_TOP,
        SPEC_CLASS_MAP,
        SPEC_MID,
        SPEC_RSVD1,
        SPEC_ERASE_GRP_SIZE,
        SPEC_ERASE_GROUP_MULT,
        SPEC_PROT_GRP_SPAN,
        SPEC_GRP_PROT_EN,
        SPEC_DEFAULT_ECC,
        SPEC_PROG_READ_RATIO,
        SPEC_WRITE_BLK_LEN,
        SPEC_PARTIAL_WRITE,
        SPEC_RSVD5,
        fmt_group,
        copy_flag,
        perm_protect,
        tmp_protect,
        file_fmt,
        ecc_type
    };

    logic [6:0] spec_crc;
    always_comb
    begin
        spec_crc = CRC7_INIT;
        for (int i = SPEC_BITS - 1; i >= 8; i--)
            spec_crc = crc7_step(spec_crc, spec_body[i]);
    end

    wire logic [SPEC_BITS-1:0] spec = {spec_body, spec_crc, END_VAL};

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    wire logic hit_ctrl = (paddr == OFS_CTRL);
    wire logic hit_status = (paddr == OFS_STATUS);
    wire logic hit_arg = (paddr == OFS_LAST_ARG);
    wire logic hit_spec0 = (paddr == OFS_SPEC0);
    wire logic hit_spec1 = (paddr == OFS_SPEC1);
    wire logic hit_spec2 = (paddr == OFS_SPEC2);
    wire logic hit_spec3 = (paddr == OFS_SPEC3);
    wire logic hit_any = hit_ctrl | hit_status | hit_arg | hit_spec0 | hit_spec1 | hit_spec2 | hit_spec3;
    wire logic setup = psel & ~penable;
    wire logic wr_ctrl = psel & penable & pwrite & hit_ctrl;

    wire logic [31:0] ctrl_word = {24'h000000, ecc_type, file_fmt, fmt_group, copy_flag,
        perm_protect, tmp_protect};
    wire logic [31:0] status_word = {rca, 6'h00, last_refused, last_illegal, cmd_event.index,
        rx_state != RX_IDLE, selected};
    wire logic [31:0] read_mux =
        hit_ctrl ? ctrl_word :
        hit_status ? status_word :
        hit_arg ? last_arg :
        hit_spec0 ? spec[31:0] :
        hit_spec1 ? spec[63:32] :
        hit_spec2 ? spec[95:64] :
        hit_spec3 ? spec[127:96] : 32'h00000000;

    // zero wait states keeps the master simple; the read word is caught in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (setup)
            prdata <= pwrite ? 32'h00000000 : read_mux;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmp_protect <= 1'b0;
            perm_protect <= 1'b0;
            copy_flag <= 1'b0;
            fmt_group <= 1'b0;
            file_fmt <= 2'h0;
            ecc_type <= 2'h0;
        end
        else if (wr_ctrl)
        begin
            tmp_protect <= pwdata[CTRL_TMP];
            // one-time bits: once set, no write can clear them
            perm_protect <= perm_protect | pwdata[CTRL_PERM];
            copy_flag <= copy_flag | pwdata[CTRL_COPY];
            fmt_group <= pwdata[CTRL_FMT_GRP];
            file_fmt <= pwdata[CTRL_FMT_LO +: 2];
            ecc_type <= pwdata[CTRL_ECC_LO +: 2];
        end
    end

endmodule : ccf_card_cmd
`default_nettype wire

// ### dv/ccf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccf_host_model
(
    output logic link_clk,
    output logic cmd_line
);
    // ------------------------------------------------------------
    // host side of the command line
    // ------------------------------------------------------------
    // clock stands low between frames; the line is pulled up, so idle reads 1
    initial
    begin
        link_clk = 1'b0;
        cmd_line = 1'b1;
    end

    function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = n - 1; i >= 0; i--)
        begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction : crc7

    // flaw: 0 clean, 1 bad checksum, 2 bad end bit, 3 bad direction bit
    task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic [1:0] flaw);
        logic [47:0] f;
        f[47:8] = {1'b0, flaw != 2'h3, idx, arg};
        f[7:1] = crc7({80'h0, f[47:8]}, 40) ^ {6'h00, flaw == 2'h1};
        f[0] = flaw != 2'h2;
        // keep line changes away from the card clock edges
        #3;
        for (int i = 47; i >= 0; i--)
        begin
            cmd_line = f[i];
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
        cmd_line = 1'b1;
    endtask : send
endmodule : ccf_host_model
`default_nettype wire

// ### dv/ccf_card_cmd_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ccf_card_cmd_checker
    import ccf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_clk,
    input wire logic cmd_line,
    input wire ccf_event_t cmd_event,
    input wire logic cmd_event_valid,
    input wire logic frame_dropped
);
    // ------------------------------------------------------------
    // cycles since the last raw link clock rise
    // ------------------------------------------------------------
    logic lc_q;
    logic [7:0] quiet;
    wire logic mapped = paddr inside {OFS_CTRL, OFS_STATUS, OFS_LAST_ARG, OFS_SPEC0, OFS_SPEC1, OFS_SPEC2,
        OFS_SPEC3};
    wire logic pulse = cmd_event_valid || frame_dropped;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lc_q <= 1'b0;
            quiet <= 8'hff;
        end
        else
        begin
            lc_q <= link_clk;
            if (link_clk && !lc_q)
                quiet <= 8'h00;
            else if (quiet != 8'hff)
                quiet <= quiet + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_event_after_link: assert property (pulse |-> quiet <= 8'h0c)
        else $error("event without recent link clock");
    a_pulse_spacing: assert property (pulse |=> !pulse [*8])
        else $error("frame pulses too close");
    a_drop_silent: assert property (frame_dropped |-> !cmd_event_valid && $stable(cmd_event))
        else $error("dropped frame changed the event");
    a_quiet_broadcast: assert property (cmd_event_valid && cmd_event.kind == KIND_NO_REPLY |-> !cmd_event.respond)
        else $error("broadcast command answered");
    a_data_adtc: assert property (cmd_event_valid && cmd_event.data_phase |-> cmd_event.kind == KIND_ADTC)
        else $error("data phase on a non data command");
    a_refuse_nodata: assert property (cmd_event_valid && cmd_event.refused |-> !cmd_event.data_phase)
        else $error("refused command moved data");
    a_unsup_index: assert property (cmd_event_valid && cmd_event.index inside {6'h04, 6'h0b, 6'h14, 6'h20,
        6'h21, 6'h22, 6'h25} |-> cmd_event.illegal && !cmd_event.respond)
        else $error("unsupported index accepted");
    a_basic_index: assert property (cmd_event_valid && cmd_event.index inside {6'h00, 6'h01, 6'h02, 6'h03,
        6'h07, 6'h09, 6'h0a, 6'h0c, 6'h0d} |-> !cmd_event.illegal)
        else $error("basic command flagged illegal");
    a_reg_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("wrong error answer for address");
endmodule : ccf_card_cmd_checker

bind ccf_card_cmd ccf_card_cmd_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .cmd_line(cmd_line), .cmd_event(cmd_event), .cmd_event_valid(cmd_event_valid),
    .frame_dropped(frame_dropped));
`default_nettype wire

// ### dv/ccf_card_cmd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ccf_card_cmd_tb_top;
    import ccf_pkg::*;
    localparam logic [31:0] TOP_V = 32'h0026012a;
    localparam logic [35:0] MID_V = 36'h900000000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_clk;
    logic cmd_line;
    logic cmd_event_valid;
    logic frame_dropped;
    ccf_event_t cmd_event;
    ccf_event_t ev;
    int err_count = 0;
    int compares = 0;
    int nv = 0;
    int nd = 0;
    logic [31:0] rd;
    logic er;
    logic [5:0] unsup [7] = '{6'h04, 6'h0b, 6'h14, 6'h20, 6'h21, 6'h22, 6'h25};

    always #5 pclk = ~pclk;
    ccf_card_cmd #(.SPEC_TOP(TOP_V), .SPEC_MID(MID_V)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .cmd_line(cmd_line), .cmd_event(cmd_event),
        .cmd_event_valid(cmd_event_valid), .frame_dropped(frame_dropped));
    ccf_host_model u_host (.link_clk(link_clk), .cmd_line(cmd_line));
    // pulses last one cycle, so they are caught here rather than by the tests
    always @(posedge pclk) if (cmd_event_valid === 1'b1) ev = cmd_event;
    always @(posedge pclk) if (cmd_event_valid === 1'b1) nv++;
    always @(posedge pclk) if (frame_dropped === 1'b1) nd++;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // x is the expected {illegal, respond, data_phase, refused}
    task automatic cmd(input logic [5:0] i, input logic [31:0] a, input logic [1:0] f, input logic [3:0] x);
        int v0;
        int d0;
        int n;
        v0 = nv;
        d0 = nd;
        n = 0;
        u_host.send(i, a, f);
        while (nv == v0 && nd == d0 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        check({32'(nv - v0), 32'(nd - d0)}, {32'(f == 2'h0), 32'(f != 2'h0)});
        if (f == 2'h0)
            check({ev.index, ev.arg, ev.illegal, ev.respond, ev.data_phase, ev.refused}, {i, a, x});
    endtask : cmd

    task automatic spec_chk(input logic [7:0] c);
        logic [119:0] b;
        logic [127:0] e;
        logic [31:0] d;
        logic x;
        b = {TOP_V, 12'h0f5, MID_V, 6'h00, 5'h1f, 5'h08, 1'b1, 2'h0, 3'h4, 4'h9, 6'h00,
            c[3], c[2], c[1], c[0], c[5:4], c[7:6]};
        e = {b, u_host.crc7(b, 120), 1'b1};
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, OFS_SPEC0 + 12'(4 * k), 32'h0, d, x);
            check({x, d}, {1'b0, e[32 * k +: 32]});
        end
    endtask : spec_chk

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        spec_chk(8'h00);
        apb(1'b0, OFS_CTRL, 32'h0, rd, er);
        check(rd, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0, rd, er);
        check({er, rd}, {1'b1, 32'h0});
        $display("test registers done");
        cmd(6'h00, 32'h0, 2'h0, 4'b0000);
        check(ev.kind, KIND_NO_REPLY);
        cmd(6'h02, 32'h0, 2'h0, 4'b0100);
        check(ev.kind, KIND_BCR);
        cmd(6'h03, 32'h12340000, 2'h0, 4'b0100);
        cmd(6'h09, 32'h55550000, 2'h0, 4'b0000);
        cmd(6'h07, 32'h12340000, 2'h0, 4'b0100);
        apb(1'b0, OFS_STATUS, 32'h0, rd, er);
        check({rd[31:16], rd[7:0]}, {16'h1234, 6'h07, 2'b01});
        cmd(6'h11, 32'h00000200, 2'h0, 4'b0110);
        check(ev.kind, KIND_ADTC);
        cmd(6'h10, 32'h80000001, 2'h0, 4'b0100);
        apb(1'b0, OFS_LAST_ARG, 32'h0, rd, er);
        check(rd, 32'h80000001);
        foreach (unsup[k]) cmd(unsup[k], 32'h0, 2'h0, 4'b1000);
        for (int k = 35; k <= 36; k++) cmd(6'(k), 32'h0, 2'h0, 4'b0100);
        for (int f = 1; f <= 3; f++) cmd(6'h0d, 32'h12340000, 2'(f), 4'b0000);
        cmd(6'h0d, 32'h12340000, 2'h0, 4'b0100);
        $display("test commands done");
        apb(1'b1, OFS_CTRL, 32'h79, rd, er);
        spec_chk(8'h79);
        cmd(6'h18, 32'h0, 2'h0, 4'b0101);
        apb(1'b1, OFS_CTRL, 32'h0, rd, er);
        cmd(6'h18, 32'h0, 2'h0, 4'b0110);
        apb(1'b1, OFS_CTRL, 32'h06, rd, er);
        apb(1'b1, OFS_CTRL, 32'h0, rd, er);
        spec_chk(8'h06);
        cmd(6'h26, 32'h0, 2'h0, 4'b0101);
        apb(1'b0, OFS_STATUS, 32'h0, rd, er);
        check({rd[9:8], rd[0]}, 3'b101);
        cmd(6'h07, 32'h0, 2'h0, 4'b0000);
        cmd(6'h0c, 32'h0, 2'h0, 4'b0000);
        $display("test protection done");
        wrap_up();
    end

    // twenty-five frames of 6 us each, with ample margin
    initial
    begin
        #400us;
        err_count++;
        wrap_up();
    end
endmodule : ccf_card_cmd_tb_top
`default_nettype wire
